// File: rtl/cdd_pkg.sv
package cdd_pkg;

	// Clock and execution times
	localparam int CLK_PERIOD_NS  = 100;
	localparam int CLEAR_TIME_NS  = 1530000;
	localparam int EXEC_TIME_NS   = 39000;
	localparam int DATA_TIME_NS   = 43000;
	localparam int BLINK_TIME_NS  = 400000000;
	localparam int CLEAR_CYCLES   = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXEC_CYCLES    = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_CYCLES    = (DATA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLINK_CYCLES   = (BLINK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// APB map
	localparam int           APB_ADDR_W = 12;
	localparam logic [11:0]  OFS_INSTR  = 12'h000;
	localparam logic [11:0]  OFS_DATA   = 12'h004;
	localparam logic [11:0]  OFS_STATUS = 12'h008;

	// RAM geometry and values
	localparam int           DISP_DEPTH  = 128;
	localparam int           GLYPH_DEPTH = 64;
	localparam logic [7:0]   SPACE_CODE  = 8'h20;
	localparam logic [6:0]   HOME_ADDR   = 7'h00;
	localparam logic [6:0]   FILL_LAST   = 7'h7f;

	// Opcode bit: position of the highest set data bit
	localparam logic [3:0]   OP_CLEAR = 4'h0;
	localparam logic [3:0]   OP_HOME  = 4'h1;
	localparam logic [3:0]   OP_ENTRY = 4'h2;
	localparam logic [3:0]   OP_DISP  = 4'h3;
	localparam logic [3:0]   OP_SHIFT = 4'h4;
	localparam logic [3:0]   OP_FUNC  = 4'h5;
	localparam logic [3:0]   OP_GLYPH = 4'h6;
	localparam logic [3:0]   OP_DISPLAY_RAM = 4'h7;
	localparam logic [3:0]   OP_NONE  = 4'h8;

	// Field positions inside instruction bytes
	localparam int ENTRY_DIR_BIT   = 1;
	localparam int ENTRY_SHIFT_BIT = 0;
	localparam int DISP_ON_BIT     = 2;
	localparam int CURSOR_BIT      = 1;
	localparam int BLINK_BIT       = 0;
	localparam int SC_BIT          = 3;
	localparam int RL_BIT          = 2;
	localparam int WIDTH_BIT       = 4;
	localparam int LINES_BIT       = 3;
	localparam int FONT_BIT        = 2;

	// Status word layout
	localparam int STAT_DISP_ON   = 0;
	localparam int STAT_CURSOR    = 1;
	localparam int STAT_BLINK     = 2;
	localparam int STAT_DIR       = 3;
	localparam int STAT_AUTOSHIFT = 4;
	localparam int STAT_WIDTH     = 5;
	localparam int STAT_LINES     = 6;
	localparam int STAT_FONT      = 7;
	localparam int STAT_GLYPH_SEL = 8;
	localparam int STAT_BUSY      = 9;
	localparam int STAT_SHIFT_LSB = 16;

	// Reset values
	localparam logic RST_DIR       = 1'b1;
	localparam logic RST_AUTOSHIFT = 1'b0;
	localparam logic RST_DISP_ON   = 1'b0;
	localparam logic RST_CURSOR    = 1'b0;
	localparam logic RST_BLINK     = 1'b0;
	localparam logic RST_WIDTH     = 1'b1;
	localparam logic RST_LINES     = 1'b0;
	localparam logic RST_FONT      = 1'b0;

	// Cursor dot row (zero based)
	localparam logic [3:0]   CURSOR_ROW_5X7  = 4'h7;
	localparam logic [3:0]   CURSOR_ROW_5X10 = 4'ha;

endpackage

// File: rtl/cdd_ram.sv
`timescale 1ns/1ps
module cdd_ram
	import cdd_pkg::*;
#(
	parameter int DISP_WORDS  = DISP_DEPTH,
	parameter int GLYPH_WORDS = GLYPH_DEPTH
)
(
	// Clock
	input  wire logic  clk_sys,
	// Access port
	cdd_ram_if.mem     ram
);

	logic [7:0] display_ram [DISP_WORDS];
	logic [7:0] glyph_ram   [GLYPH_WORDS];

	wire [5:0] glyph_addr = ram.addr[5:0];

	if (DISP_WORDS != 128 || GLYPH_WORDS != 64)
	begin : g_check
		$error("cdd_ram: depths must match the 7-bit and 6-bit address spaces");
	end

	// Contents survive reset and display-off on purpose
	always_ff @(posedge clk_sys)
	begin
		if (ram.we && !ram.glyph_sel)
			display_ram[ram.addr] <= ram.wdata;
		if (ram.we && ram.glyph_sel)
			glyph_ram[glyph_addr] <= ram.wdata;
	end

	assign ram.rdata = ram.glyph_sel ? glyph_ram[glyph_addr] : display_ram[ram.addr];

endmodule

// File: rtl/cdd_ram_if.sv
`timescale 1ns/1ps
interface cdd_ram_if;
	logic        glyph_sel;
	logic        we;
	logic [6:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;

	modport ctrl (output glyph_sel, output we, output addr, output wdata, input rdata);
	modport mem  (input glyph_sel, input we, input addr, input wdata, output rdata);
endinterface

// File: rtl/cdd_top.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module cdd_top
	import cdd_pkg::*;
#(
	parameter int CLEAR_CYC = CLEAR_CYCLES,
	parameter int BLINK_CYC = BLINK_CYCLES
)
(
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   reset,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [APB_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]            pwdata,
	output      logic [31:0]            prdata,
	output      logic                   pready,
	output      logic                   pslverr,
	// Display state
	output      logic                   display_on,
	output      logic                   cursor_draw,
	output      logic [3:0]             cursor_row,
	output      logic                   blink_solid,
	output      logic [6:0]             cursor_addr,
	output      logic [6:0]             display_shift,
	output      logic                   two_line,
	output      logic                   font_5x10,
	output      logic                   busy_flag
);

	localparam int BUSY_W  = $clog2(CLEAR_CYC + 1);
	localparam int BLINK_W = $clog2(BLINK_CYC + 1);

	if (CLEAR_CYC < DATA_CYCLES || BLINK_CYC < 2)
	begin : g_check
		$error("cdd_top: clear time must exceed data time and blink count be at least 2");
	end

	function automatic logic [3:0] top_bit(input logic [7:0] b);
		logic [3:0] idx;
		idx = OP_NONE;
		for (int i = 0; i < 8; i++)
			if (b[i])
				idx = 4'(i);
		return idx;
	endfunction

	cdd_ram_if ram ();

	cdd_ram u_ram
	(
		.clk_sys (clk_sys),
		.ram     (ram)
	);

	// State registers
	logic [BUSY_W-1:0]   busy_cnt_reg;
	logic [BUSY_W-1:0]   busy_cnt_next;
	logic [6:0]          address_counter_reg;
	logic [6:0]          address_counter_next;
	logic                step_pend_reg;
	logic                step_pend_next;
	logic [6:0]          shift_reg;
	logic [6:0]          shift_next;
	logic                clearing_reg;
	logic [6:0]          fill_addr_reg;
	logic                nib_phase_reg;
	logic [3:0]          nib_hi_reg;
	logic                entry_dir_reg;
	logic                entry_autoshift_reg;
	logic                disp_on_reg;
	logic                cursor_on_reg;
	logic                blink_on_reg;
	logic                bus_width_sel_reg;
	logic                lines_reg;
	logic                font_reg;
	logic                glyph_sel_reg;
	logic [BLINK_W-1:0]  blink_cnt_reg;
	logic                blink_phase_reg;
	logic                pready_reg;
	logic                pslverr_reg;
	logic [31:0]         prdata_reg;
	logic                cursor_draw_reg;
	logic [3:0]          cursor_row_reg;
	logic                blink_solid_reg;

	// Bus decode
	wire        apb_first   = psel & penable & ~pready_reg;
	wire        apb_done    = psel & penable & pready_reg;
	wire        hit_instr   = paddr == OFS_INSTR;
	wire        hit_data    = paddr == OFS_DATA;
	wire        hit_stat    = paddr == OFS_STATUS;
	wire        unmapped    = ~(hit_instr | hit_data | hit_stat);
	wire        busy        = busy_cnt_reg != '0;
	wire        busy_end    = busy_cnt_reg == BUSY_W'(1);
	wire        four_bit    = ~bus_width_sel_reg;
	wire        nib_last    = ~four_bit | nib_phase_reg;
	wire        port_access = hit_instr | hit_data;

	// Only the busy-flag read and status register accesses get through while busy
	// refuse while busy
	wire        refuse      = busy & (hit_data | (hit_instr & pwrite));
	wire        bad_access  = unmapped | refuse;
	wire        accepted    = apb_done & ~pslverr_reg;

	wire [7:0]  byte_in     = four_bit ? {nib_hi_reg, pwdata[7:4]} : pwdata[7:0];

	wire        cmd_go      = accepted & hit_instr & pwrite & nib_last;
	wire        wr_go       = accepted & hit_data & pwrite & nib_last;
	wire        rd_go       = accepted & hit_data & ~pwrite & nib_last;
	wire        data_go     = wr_go | rd_go;

	wire [3:0]  opcode      = top_bit(byte_in);
	wire        op_clear    = cmd_go & (opcode == OP_CLEAR);
	wire        op_home     = cmd_go & (opcode == OP_HOME);
	wire        op_entry    = cmd_go & (opcode == OP_ENTRY);
	wire        op_disp     = cmd_go & (opcode == OP_DISP);
	wire        op_shift    = cmd_go & (opcode == OP_SHIFT);
	wire        op_func     = cmd_go & (opcode == OP_FUNC);
	wire        op_glyph    = cmd_go & (opcode == OP_GLYPH);
	wire        op_display_ram    = cmd_go & (opcode == OP_DISPLAY_RAM);
	wire        op_any      = cmd_go & (opcode != OP_NONE);

	// Read path
	// busy flag over counter
	wire [7:0]  rd_byte     = hit_instr ? {busy, address_counter_reg} : ram.rdata;
	wire [7:0]  rd_lane     = ~four_bit ? rd_byte :
	                          nib_phase_reg ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0};
	wire [31:0] status_word = {9'h000, shift_reg, 6'h00, busy, glyph_sel_reg, font_reg, lines_reg,
	                           bus_width_sel_reg, entry_autoshift_reg, entry_dir_reg, blink_on_reg,
	                           cursor_on_reg, disp_on_reg};
	wire [31:0] read_word   = hit_stat ? status_word : unmapped ? 32'h0000_0000 : {24'h000000, rd_lane};

	// RAM port; the clear sweep owns it while running, data access cannot collide as busy holds off
	// space fill sweep
	assign ram.glyph_sel = clearing_reg ? 1'b0 : glyph_sel_reg;
	assign ram.addr      = clearing_reg ? fill_addr_reg : address_counter_reg;
	assign ram.we        = clearing_reg | wr_go;
	assign ram.wdata     = clearing_reg ? SPACE_CODE : byte_in;

	// Busy timer
	// execution times
	always_comb
	begin
		busy_cnt_next = busy ? busy_cnt_reg - BUSY_W'(1) : busy_cnt_reg;
		if (op_clear || op_home)
			busy_cnt_next = BUSY_W'(CLEAR_CYC);
		else if (op_any)
			busy_cnt_next = BUSY_W'(EXEC_CYCLES);
		else if (data_go)
			busy_cnt_next = BUSY_W'(DATA_CYCLES);
	end

	// Address counter and display shift
	always_comb
	begin
		address_counter_next = address_counter_reg;
		step_pend_next       = step_pend_reg;
		shift_next           = shift_reg;
		if (step_pend_reg && busy_end)
		begin
			address_counter_next = entry_dir_reg ? address_counter_reg + 7'h01 : address_counter_reg - 7'h01;
			step_pend_next       = 1'b0;
		end
		if (data_go)
			step_pend_next = 1'b1;
		if (wr_go && entry_autoshift_reg && !glyph_sel_reg)
			shift_next = entry_dir_reg ? shift_reg + 7'h01 : shift_reg - 7'h01;
		if (op_clear || op_home)
		begin
			address_counter_next = HOME_ADDR;
			shift_next           = '0;
		end
		if (op_shift && !byte_in[SC_BIT])
			address_counter_next = byte_in[RL_BIT] ? address_counter_reg + 7'h01 : address_counter_reg - 7'h01;
		if (op_shift && byte_in[SC_BIT])
			shift_next = byte_in[RL_BIT] ? shift_reg - 7'h01 : shift_reg + 7'h01;
		if (op_glyph)
			address_counter_next = {1'b0, byte_in[5:0]};
		if (op_display_ram)
			address_counter_next = byte_in[6:0];
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			busy_cnt_reg        <= '0;
			address_counter_reg <= HOME_ADDR;
			step_pend_reg       <= 1'b0;
			shift_reg           <= '0;
		end
		else
		begin
			busy_cnt_reg        <= busy_cnt_next;
			address_counter_reg <= address_counter_next;
			step_pend_reg       <= step_pend_next;
			shift_reg           <= shift_next;
		end
	end

	// Clear sweep covers the whole array, well inside the clear time
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			clearing_reg  <= 1'b0;
			fill_addr_reg <= '0;
		end
		else if (op_clear)
		begin
			clearing_reg  <= 1'b1;
			fill_addr_reg <= '0;
		end
		else if (clearing_reg)
		begin
			clearing_reg  <= fill_addr_reg != FILL_LAST;
			fill_addr_reg <= fill_addr_reg + 7'h01;
		end
	end

	// Nibble pairing, resynced by every executed instruction
	// two nibbles per byte
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			nib_phase_reg <= 1'b0;
			nib_hi_reg    <= '0;
		end
		else if (cmd_go || !four_bit)
			nib_phase_reg <= 1'b0;
		else if (accepted && port_access)
		begin
			nib_phase_reg <= ~nib_phase_reg;
			if (!nib_phase_reg)
				nib_hi_reg <= pwdata[7:4];
		end
	end

	// Mode latches
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			entry_dir_reg       <= RST_DIR;
			entry_autoshift_reg <= RST_AUTOSHIFT;
			disp_on_reg         <= RST_DISP_ON;
			cursor_on_reg       <= RST_CURSOR;
			blink_on_reg        <= RST_BLINK;
			bus_width_sel_reg   <= RST_WIDTH;
			lines_reg           <= RST_LINES;
			font_reg            <= RST_FONT;
			glyph_sel_reg       <= 1'b0;
		end
		else
		begin
			if (op_clear)
				entry_dir_reg <= 1'b1;
			if (op_entry)
			begin
				entry_dir_reg       <= byte_in[ENTRY_DIR_BIT];
				entry_autoshift_reg <= byte_in[ENTRY_SHIFT_BIT];
			end
			if (op_disp)
			begin
				disp_on_reg   <= byte_in[DISP_ON_BIT];
				cursor_on_reg <= byte_in[CURSOR_BIT];
				blink_on_reg  <= byte_in[BLINK_BIT];
			end
			if (op_func)
			begin
				bus_width_sel_reg <= byte_in[WIDTH_BIT];
				lines_reg         <= byte_in[LINES_BIT];
				font_reg          <= byte_in[FONT_BIT];
			end
			if (op_glyph)
				glyph_sel_reg <= 1'b1;
			if (op_display_ram)
				glyph_sel_reg <= 1'b0;
		end
	end

	// Blink timebase free-runs so the phase never stalls mid-interval
	// 0.4 s alternation
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			blink_cnt_reg   <= '0;
			blink_phase_reg <= 1'b0;
		end
		else if (blink_cnt_reg == BLINK_W'(BLINK_CYC - 1))
		begin
			blink_cnt_reg   <= '0;
			blink_phase_reg <= ~blink_phase_reg;
		end
		else
			blink_cnt_reg <= blink_cnt_reg + BLINK_W'(1);
	end

	// Display outputs
	// cursor row by font
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			cursor_draw_reg <= 1'b0;
			cursor_row_reg  <= CURSOR_ROW_5X7;
			blink_solid_reg <= 1'b0;
		end
		else
		begin
			cursor_draw_reg <= disp_on_reg & cursor_on_reg;
			cursor_row_reg  <= font_reg ? CURSOR_ROW_5X10 : CURSOR_ROW_5X7;
			blink_solid_reg <= disp_on_reg & blink_on_reg & blink_phase_reg;
		end
	end

	// APB answer: one wait state, so read data is settled before pready
	// read selected RAM
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= '0;
		end
		else
		begin
			pready_reg <= apb_first;
			if (apb_first)
			begin
				pslverr_reg <= bad_access;
				prdata_reg  <= read_word;
			end
			else if (apb_done)
				pslverr_reg <= 1'b0;
		end
	end

	assign pready        = pready_reg;
	assign pslverr       = pslverr_reg & pready_reg;
	assign prdata        = prdata_reg;
	assign display_on    = disp_on_reg;
	assign cursor_draw   = cursor_draw_reg;
	assign cursor_row    = cursor_row_reg;
	assign blink_solid   = blink_solid_reg;
	assign cursor_addr   = address_counter_reg;
	assign display_shift = shift_reg;
	assign two_line      = lines_reg;
	assign font_5x10     = font_reg;
	assign busy_flag     = busy;

endmodule

// File: tb/cdd_assertions.sv
`timescale 1ns/1ps
module cdd_assertions
	import cdd_pkg::*;
#(
	parameter int CLEAR_CYC = CLEAR_CYCLES,
	parameter int BLINK_CYC = BLINK_CYCLES
)
(
	// Clock and reset
	input wire logic                  clk_sys,
	input wire logic                  reset,
	// APB
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [APB_ADDR_W-1:0] paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	// Display state
	input wire logic                  display_on,
	input wire logic                  cursor_draw,
	input wire logic [3:0]            cursor_row,
	input wire logic                  blink_solid,
	input wire logic [6:0]            cursor_addr,
	input wire logic [6:0]            display_shift,
	input wire logic                  two_line,
	input wire logic                  font_5x10,
	input wire logic                  busy_flag
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	int   busy_len_reg;
	logic wide_reg;
	wire  done_ok = psel && penable && pready && !pslverr && wide_reg;
	wire  ins_ok  = done_ok && pwrite && paddr == OFS_INSTR;
	wire  dat_ok  = done_ok && paddr == OFS_DATA;
	wire  mapped  = paddr == OFS_INSTR || paddr == OFS_DATA || paddr == OFS_STATUS;

	// Nibble pairing not modelled: checks on executions stop in 4-bit mode
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			busy_len_reg <= 0;
			wide_reg     <= 1'b1;
		end
		else
		begin
			busy_len_reg <= busy_flag ? busy_len_reg + 1 : 0;
			if (ins_ok && pwdata[7:5] == 3'b001)
				wide_reg <= pwdata[4];
		end

	a_ready_wait: assert property (psel && !penable ##1 psel && penable |=> pready)
		else $error("no answer in second access cycle");
	a_busy_refuse: assert property (pready && $past(busy_flag) && (paddr == OFS_DATA || pwrite && paddr == OFS_INSTR)
		|-> pslverr) else $error("request taken while busy");
	a_unmapped_err: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_busy_length: assert property ($fell(busy_flag)
		|-> busy_len_reg == CLEAR_CYC || busy_len_reg == EXEC_CYCLES || busy_len_reg == DATA_CYCLES)
		else $error("busy length wrong");
	a_exec_busy: assert property (ins_ok && pwdata[7:0] != 8'h00 || dat_ok |=> busy_flag)
		else $error("busy not raised");
	a_clear_home: assert property (ins_ok && pwdata[7:2] == 6'h00 && pwdata[1:0] != 2'b00
		|=> cursor_addr == 7'h00 && display_shift == 7'h00) else $error("clear or home position wrong");
	a_addr_load: assert property (ins_ok && pwdata[7:6] != 2'b00
		|=> cursor_addr == ($past(pwdata[7]) ? $past(pwdata[6:0]) : {1'b0, $past(pwdata[5:0])}))
		else $error("address load wrong");
	a_addr_steady: assert property (busy_flag && $past(busy_flag) |-> $stable(cursor_addr))
		else $error("address moved while busy");
	a_display_ctl: assert property (ins_ok && pwdata[7:3] == 5'h01 |=> display_on == $past(pwdata[2])
		##1 cursor_draw == ($past(pwdata[2], 2) && $past(pwdata[1], 2))) else $error("display control wrong");

	c_clear: cover property (ins_ok && pwdata[7:0] == 8'h01);
	c_refused: cover property (pready && pslverr && busy_flag);
	c_data_read: cover property (dat_ok && !pwrite);
	c_four_bit: cover property (!wide_reg && pready && !pslverr && paddr == OFS_DATA);
endmodule

bind cdd_top cdd_assertions #(.CLEAR_CYC(CLEAR_CYC), .BLINK_CYC(BLINK_CYC)) u_chk (.clk_sys, .reset, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .display_on, .cursor_draw, .cursor_row,
	.blink_solid, .cursor_addr, .display_shift, .two_line, .font_5x10, .busy_flag);

// File: tb/cdd_host.sv
`timescale 1ns/1ps
module cdd_host
	import cdd_pkg::*;
(
	// Clock
	input  wire logic                  clk_sys,
	// APB master
	output logic                       psel,
	output logic                       penable,
	output logic                       pwrite,
	output logic [APB_ADDR_W-1:0]      paddr,
	output logic [31:0]                pwdata,
	input  wire logic [31:0]           prdata,
	input  wire logic                  pready
);
	logic [31:0] rdata;
	logic        tmo;

	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		tmo = 1'b0;
	end

	task automatic xfer(input logic w, input logic [APB_ADDR_W-1:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 64);
		if (pready !== 1'b1)
			tmo <= 1'b1;
		rdata = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released bus must not keep showing the old values
		paddr <= ~ad;
		pwdata <= ~d;
	endtask

	task automatic wait_idle();
		int k;
		k = 0;
		do
		begin
			xfer(1'b0, OFS_INSTR, 32'h0);
			k++;
		end
		while (rdata[7] !== 1'b0 && k < 8000);
		if (rdata[7] !== 1'b0)
			tmo <= 1'b1;
	endtask
endmodule

// File: tb/tb_char_display_instruction_decoder.sv
`timescale 1ns/1ps
module tb_char_display_instruction_decoder
	import cdd_pkg::*;
;
	localparam int CLR = 600;
	localparam int BLK = 8;

	logic                 clk_sys;
	logic                 reset;
	wire                  psel;
	wire                  penable;
	wire                  pwrite;
	wire [APB_ADDR_W-1:0] paddr;
	wire [31:0]           pwdata;
	wire [31:0]           prdata;
	wire                  pready;
	wire                  pslverr;
	wire                  display_on;
	wire                  cursor_draw;
	wire [3:0]            cursor_row;
	wire                  blink_solid;
	wire [6:0]            cursor_addr;
	wire [6:0]            display_shift;
	wire                  two_line;
	wire                  font_5x10;
	wire                  busy_flag;
	int                   err_total;
	int                   comparisons;
	logic [65:0]          notes[$];
	logic [65:0]          note;
	logic [6:0]           ac;
	logic [6:0]           sh;
	logic [6:0]           a;
	logic [7:0]           b;
	logic                 seen;

	cdd_top #(.CLEAR_CYC(CLR), .BLINK_CYC(BLK)) dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .display_on, .cursor_draw, .cursor_row, .blink_solid,
		.cursor_addr, .display_shift, .two_line, .font_5x10, .busy_flag);
	cdd_host host (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);

	always #50 clk_sys = ~clk_sys;

	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g, input logic [32:0] m = '1);
		comparisons++;
		if (((g ^ e) & m) !== 33'h0)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e & m, g & m);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic xp(input logic w, input logic [APB_ADDR_W-1:0] ad, input logic [7:0] d,
		input logic [32:0] e, input logic [32:0] m);
		notes.push_back({e, m});
		host.xfer(w, ad, {24'h0, d});
	endtask

	task automatic ins(input logic [7:0] d);
		xp(1'b1, OFS_INSTR, d, 33'h0, 33'h1_0000_0000);
		host.wait_idle();
	endtask

	task automatic dwr(input logic [7:0] d);
		xp(1'b1, OFS_DATA, d, 33'h0, 33'h1_0000_0000);
		host.wait_idle();
	endtask

	task automatic drd(input logic [7:0] d);
		xp(1'b0, OFS_DATA, 8'h0, {25'h0, d}, 33'h1_0000_00ff);
		host.wait_idle();
	endtask

	task automatic ird(input logic [7:0] e);
		xp(1'b0, OFS_INSTR, 8'h0, {25'h0, e}, 33'h1_0000_00ff);
	endtask

	task automatic srd(input logic [31:0] e, input logic [31:0] m);
		xp(1'b0, OFS_STATUS, 8'h0, {1'b0, e}, {1'b1, m});
	endtask

	// two nibbles on pwdata[7:4], high first
	task automatic nib(input logic w, input logic [APB_ADDR_W-1:0] ad, input logic [7:0] d, input logic [7:0] e);
		xp(w, ad, {d[7:4], 4'h0}, {25'h0, e[7:4], 4'h0}, w ? 33'h1_0000_0000 : 33'h1_0000_00ff);
		xp(w, ad, {d[3:0], 4'h0}, {25'h0, e[3:0], 4'h0}, w ? 33'h1_0000_0000 : 33'h1_0000_00ff);
		// Polling would split a pair, so wait out the longest data time
		repeat (DATA_CYCLES + 8) @(posedge clk_sys);
	endtask

	always @(negedge clk_sys)
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && notes.size() > 0)
		begin
			note = notes.pop_front();
			chk("apb", note[65:33], {pslverr, prdata}, note[32:0]);
		end

	always @(posedge clk_sys)
		if (host.tmo === 1'b1)
		begin
			err_total++;
			summarize();
		end

	initial
	begin
		clk_sys = 1'b0;
		reset = 1'b1;
		err_total = 0;
		comparisons = 0;
		sh = 7'h0;
		void'($urandom(12325));
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		srd(32'h28, 32'h007f_03ff);
		ird(8'h00);
		xp(1'b0, 12'h00c, 8'h0, {1'b1, 32'h0}, '1);
		xp(1'b1, OFS_STATUS, 8'hff, 33'h0, 33'h1_0000_0000);
		srd(32'h28, 32'h007f_03ff);
		$display("test reset done");
		ins(8'h04);
		srd(32'h20, 32'h38);
		xp(1'b1, OFS_INSTR, 8'h01, 33'h0, 33'h1_0000_0000);
		ird(8'h80);
		xp(1'b1, OFS_DATA, 8'h55, {1'b1, 32'h0}, 33'h1_0000_0000);
		xp(1'b0, OFS_DATA, 8'h0, {1'b1, 32'h0}, 33'h1_0000_0000);
		host.wait_idle();
		srd(32'h28, 32'h38);
		a = 7'($urandom_range(0, 127));
		ins({1'b1, a});
		drd(8'h20);
		$display("test clear done");
		for (int i = 0; i < 4; i++)
		begin
			ins({6'h01, 2'(i)});
			a = 7'($urandom_range(8, 119));
			b = 8'($urandom);
			ins({1'b1, a});
			dwr(b);
			ac = i[1] ? a + 7'h1 : a - 7'h1;
			if (i[0])
				sh = i[1] ? sh + 7'h1 : sh - 7'h1;
			ird({1'b0, ac});
			chk("shift", {26'h0, sh}, {26'h0, display_shift});
			ins({1'b1, a});
			drd(b);
			ird({1'b0, ac});
			chk("shift", {26'h0, sh}, {26'h0, display_shift});
			ins({2'b01, a[5:0]});
			dwr(~b);
			ins({2'b01, a[5:0]});
			drd(~b);
			chk("shift", {26'h0, sh}, {26'h0, display_shift});
		end
		$display("test entry done");
		for (int i = 0; i < 8; i++)
		begin
			ins({5'h01, 3'(i)});
			chk("display_on", {32'h0, i[2]}, {32'h0, display_on});
			chk("cursor_draw", {32'h0, i[2] & i[1]}, {32'h0, cursor_draw});
			seen = 1'b0;
			repeat (2 * BLK + 4)
			begin
				@(negedge clk_sys);
				seen = seen | blink_solid;
			end
			chk("blink_solid", {32'h0, i[2] & i[0]}, {32'h0, seen});
		end
		ins({1'b1, a});
		drd(b);
		$display("test display done");
		for (int i = 0; i < 4; i++)
		begin
			ins({4'h3, 2'(i), 2'b00});
			chk("two_line", {32'h0, i[1]}, {32'h0, two_line});
			chk("font_5x10", {32'h0, i[0]}, {32'h0, font_5x10});
			chk("cursor_row", i[0] ? 33'ha : 33'h7, {29'h0, cursor_row});
			srd({24'h0, i[0], i[1], 6'h20}, 32'he0);
		end
		$display("test function done");
		ins(8'hc0);
		ac = 7'h40;
		for (int i = 0; i < 4; i++)
		begin
			ins({4'h1, 2'(i), 2'b00});
			if (i[1])
				sh = i[0] ? sh - 7'h1 : sh + 7'h1;
			else
				ac = i[0] ? ac + 7'h1 : ac - 7'h1;
			ird({1'b0, ac});
			chk("shift", {26'h0, sh}, {26'h0, display_shift});
		end
		ins(8'h18);
		ins({7'h01, 1'($urandom)});
		ird(8'h00);
		chk("shift", 33'h0, {26'h0, display_shift});
		ins({1'b1, a});
		drd(b);
		$display("test shift_home done");
		xp(1'b1, OFS_INSTR, 8'h28, 33'h0, 33'h1_0000_0000);
		repeat (DATA_CYCLES + 8) @(posedge clk_sys);
		srd(32'h40, 32'he0);
		nib(1'b1, OFS_INSTR, {1'b1, a}, 8'h0);
		nib(1'b1, OFS_DATA, ~b, 8'h0);
		chk("shift", 33'h1, {26'h0, display_shift});
		nib(1'b1, OFS_INSTR, {1'b1, a}, 8'h0);
		nib(1'b0, OFS_DATA, 8'h0, ~b);
		nib(1'b0, OFS_INSTR, 8'h0, {1'b0, a + 7'h1});
		$display("test nibble done");
		summarize();
	end
endmodule
